// File: hdl/station_switch_display.v
// station switch capture, status display and output-loss control
// assumes status inputs synchronous to i_clk_sys; switches static
`timescale 1ns/1ps
`include "station_display_defines.vh"
module station_switch_display #(
   parameter DIGIT_ON_CYC    = `MS_TO_CYCLES(`DIGIT_ON_MS),
   parameter SHORT_PAUSE_CYC = `MS_TO_CYCLES(`SHORT_PAUSE_MS),
   parameter LONG_PAUSE_CYC  = `MS_TO_CYCLES(`LONG_PAUSE_MS)
) (
   // clock and reset
   input  wire        i_clk_sys,
   input  wire        i_rst,
   // option switches, address_msb_switch first
   input  wire [6:0]  i_address_switch,
   input  wire        i_display_select_switch,
   input  wire        i_spare_option_switch,
   // output_loss_jumper: present and hold position
   input  wire        i_output_loss_jumper_present,
   input  wire        i_output_loss_jumper_hold,
   // status from the protocol engine and base
   input  wire        i_comm_ok,
   input  wire        i_config_received,
   input  wire        i_module_mismatch,
   input  wire        i_wrong_module,
   input  wire        i_wrong_slot,
   input  wire [1:0]  i_diag_fail,
   input  wire        i_lenient_mismatch_option,
   // discrete outputs from the master
   input  wire [15:0] i_discrete_out,
   // captured configuration, and the live online enable
   output reg  [6:0]  o_station_addr,
   output reg         o_addr_valid,
   output reg         o_online_enable,
   // display
   output reg  [4:0]  o_display_char,
   output reg         o_display_point,
   // discrete outputs to the base
   output reg  [15:0] o_discrete_out
);
   // ==========================================================
   // address display sequencer states
   localparam [2:0] ST_HUND  = 3'h0;
   localparam [2:0] ST_GAP1  = 3'h1;
   localparam [2:0] ST_TENS  = 3'h2;
   localparam [2:0] ST_GAP2  = 3'h3;
   localparam [2:0] ST_ONES  = 3'h4;
   localparam [2:0] ST_LONG  = 3'h5;

   reg         sampled_reg;
   reg         show_addr_reg;
   reg         hold_mode_reg;
   reg  [2:0]  seq_reg;
   reg  [2:0]  seq_next;
   reg  [27:0] tmr_reg;
   reg  [4:0]  char_next;
   wire [3:0]  dig_h;
   wire [3:0]  dig_t;
   wire [3:0]  dig_o;
   wire [6:0]  addr_now;
   wire        addr_ok;
   wire        tmr_done;
   wire        diag_active;

   // ==========================================================
   // helper functions
   // station numbers kept back from use; checked once at capture
   function addr_reserved;
      input [6:0] addr;
      begin
         addr_reserved = (addr >= `ADDR_INVALID_LO) && (addr <= `ADDR_INVALID_HI);
      end
   endfunction

   // digits travel as the low codes of the character set
   function [4:0] digit_char;
      input [3:0] digit;
      begin
         digit_char = {1'b0, digit};
      end
   endfunction

   // failure selector to its character; the none code gives blank
   function [4:0] diag_char;
      input [1:0] sel;
      begin
         case (sel)
            `DIAG_ONE: diag_char = `CHAR_1;
            `DIAG_A:   diag_char = `CHAR_UP_A;
            `DIAG_E:   diag_char = `CHAR_UP_E;
            default:   diag_char = `CHAR_BLANK;
         endcase
      end
   endfunction

   // timer reload for the state being entered; every count runs down to zero
   function [27:0] reload_count;
      input [2:0] state;
      begin
         case (state)
            ST_GAP1, ST_GAP2: reload_count = SHORT_PAUSE_CYC[27:0] - 28'h0000001;
            ST_LONG:          reload_count = LONG_PAUSE_CYC[27:0] - 28'h0000001;
            default:          reload_count = DIGIT_ON_CYC[27:0] - 28'h0000001;
         endcase
      end
   endfunction

   // the spare switch is deliberately left unread
   // i_spare_option_switch has no function
   // open switch reads as one; bit 6 carries the msb switch
   assign addr_now    = i_address_switch;
   assign addr_ok     = !addr_reserved(addr_now);
   assign diag_active = (i_diag_fail != `DIAG_NONE);

   address_digit_split u_split (
      .i_addr     (o_station_addr),
      .o_hundreds (dig_h),
      .o_tens     (dig_t),
      .o_ones     (dig_o)
   );

   // ==========================================================
   // one-shot switch capture after reset release
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sampled_reg    <= 1'b0;
         o_station_addr <= 7'h00;
         o_addr_valid   <= 1'b0;
         show_addr_reg  <= 1'b0;
         hold_mode_reg  <= 1'b0;
      end else if (!sampled_reg) begin
         sampled_reg    <= 1'b1;
         o_station_addr <= addr_now;
         o_addr_valid   <= addr_ok;
         show_addr_reg  <= i_display_select_switch;
         // absent jumper reads as off
         hold_mode_reg  <= i_output_loss_jumper_present & i_output_loss_jumper_hold;
      end
   end

   // ==========================================================
   // address sequencer
   assign tmr_done = (tmr_reg == 28'h0000000);

   always @* begin
      seq_next = seq_reg;
      if (tmr_done) begin
         case (seq_reg)
            ST_HUND: seq_next = ST_GAP1;
            ST_GAP1: seq_next = ST_TENS;
            ST_TENS: seq_next = ST_GAP2;
            ST_GAP2: seq_next = ST_ONES;
            ST_ONES: seq_next = ST_LONG;
            default: seq_next = ST_HUND;
         endcase
      end
   end

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         seq_reg <= ST_HUND;
         tmr_reg <= 28'h0000000;
      end else if (!sampled_reg || !show_addr_reg) begin
         // parked here, so address mode always opens on the hundreds digit
         seq_reg <= ST_HUND;
         tmr_reg <= reload_count(ST_HUND);
      end else begin
         seq_reg <= seq_next;
         if (!tmr_done) begin
            tmr_reg <= tmr_reg - 28'h0000001;
         end else begin
            tmr_reg <= reload_count(seq_next);
         end
      end
   end

   // ==========================================================
   // character selection; address mode outranks failures, failures outrank every other status
   always @* begin
      char_next = `CHAR_BLANK;
      if (show_addr_reg) begin
         case (seq_reg)
            ST_HUND: char_next = digit_char(dig_h);
            ST_TENS: char_next = digit_char(dig_t);
            ST_ONES: char_next = digit_char(dig_o);
            default: char_next = `CHAR_BLANK;
         endcase
      end else if (diag_active) begin
         char_next = diag_char(i_diag_fail);
      end else if (i_wrong_slot) begin
         char_next = `CHAR_LO_B;
      end else if (!i_comm_ok) begin
         char_next = `CHAR_3;
      end else if (!i_config_received) begin
         char_next = `CHAR_7;
      end else if (i_wrong_module && !i_lenient_mismatch_option) begin
         char_next = `CHAR_LO_A;
      end else if (i_module_mismatch) begin
         char_next = `CHAR_2;
      end else begin
         char_next = `CHAR_0;
      end
   end

   // ==========================================================
   // registered outputs
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_display_char  <= `CHAR_BLANK;
         o_display_point <= 1'b0;
         o_online_enable <= 1'b0;
         o_discrete_out  <= 16'h0000;
      end else begin
         o_display_char  <= sampled_reg ? char_next : `CHAR_BLANK;
         o_display_point <= sampled_reg & !show_addr_reg & i_lenient_mismatch_option;
         // address verdict is frozen at capture; failures gate online live
         o_online_enable <= sampled_reg & o_addr_valid & !diag_active
                            & !i_wrong_slot;
         // hold keeps the image last passed while the link was up
         if (i_comm_ok) begin
            o_discrete_out <= i_discrete_out;
         end else if (!hold_mode_reg) begin
            o_discrete_out <= 16'h0000;
         end
      end
   end
endmodule

// File: hdl/station_display_defines.vh
// constants for the station switch and status display block
// assumes a 100 MHz system clock; included by hdl/ design files only
`ifndef STATION_DISPLAY_DEFINES_VH
`define STATION_DISPLAY_DEFINES_VH

// ==========================================================
// address range
`define ADDR_INVALID_LO    7'h71
`define ADDR_INVALID_HI    7'h7d

// ==========================================================
// display character codes (hex digit, then letters)
`define CHAR_0             5'h00
`define CHAR_1             5'h01
`define CHAR_2             5'h02
`define CHAR_3             5'h03
`define CHAR_7             5'h07
`define CHAR_UP_A          5'h0a
`define CHAR_UP_E          5'h0e
`define CHAR_LO_A          5'h10
`define CHAR_LO_B          5'h11
`define CHAR_BLANK         5'h1f

// ==========================================================
// diagnostic failure selector
`define DIAG_NONE          2'h0
`define DIAG_ONE           2'h1
`define DIAG_A             2'h2
`define DIAG_E             2'h3

// ==========================================================
// address display timing
`define CLK_PERIOD_NS      10
`define DIGIT_ON_MS        500
`define SHORT_PAUSE_MS     250
`define LONG_PAUSE_MS      1500
`define MS_TO_CYCLES(ms)   ((ms) * 1000000 / `CLK_PERIOD_NS)

`endif

// File: hdl/address_digit_split.v
// binary-to-decimal split of a seven-bit station address
// assumes a held input; purely combinational
`timescale 1ns/1ps
module address_digit_split (
   // address in
   input  wire [6:0] i_addr,
   // decimal digits out
   output wire [3:0] o_hundreds,
   output wire [3:0] o_tens,
   output wire [3:0] o_ones
);
   wire [6:0] rem_hund;
   wire [6:0] rem_tens;

   // max value 127, so hundreds is 0 or 1
   assign o_hundreds = (i_addr >= 7'h64) ? 4'h1 : 4'h0;
   assign rem_hund   = (i_addr >= 7'h64) ? (i_addr - 7'h64) : i_addr;
   assign o_tens     = (rem_hund >= 7'h5a) ? 4'h9 :
                       (rem_hund >= 7'h50) ? 4'h8 :
                       (rem_hund >= 7'h46) ? 4'h7 :
                       (rem_hund >= 7'h3c) ? 4'h6 :
                       (rem_hund >= 7'h32) ? 4'h5 :
                       (rem_hund >= 7'h28) ? 4'h4 :
                       (rem_hund >= 7'h1e) ? 4'h3 :
                       (rem_hund >= 7'h14) ? 4'h2 :
                       (rem_hund >= 7'h0a) ? 4'h1 : 4'h0;
   assign rem_tens   = rem_hund - ({3'h0, o_tens} * 7'h0a);
   assign o_ones     = rem_tens[3:0];
endmodule

// File: tb/fieldbus_master_model.sv
// behavioural fieldbus master feeding the block's status inputs
// assumes the bench asks for link and configuration
`timescale 1ns/1ps
module fieldbus_master_model (
   // clock
   input  wire        i_clk_sys,
   // bench requests
   input  wire        i_link_up,
   input  wire        i_send_config,
   input  wire [15:0] i_image,
   input  wire [6:0]  i_station_addr,
   // to the block
   output reg         o_comm_ok = 1'b0,
   output reg         o_config_received = 1'b0,
   output reg  [15:0] o_discrete_out = 16'h0000
);
// ==========================================
// master side
always @(posedge i_clk_sys) begin
   o_comm_ok <= i_link_up;
   // the bench hands over the switch-selected address; own-family range only
   o_config_received <= i_link_up & i_send_config & (i_station_addr >= 7'h01)
                        & (i_station_addr <= 7'h70);
   // a dead link carries no image, so the pattern keeps changing
   o_discrete_out <= i_link_up ? i_image : ~o_discrete_out;
end
endmodule

// File: tb/station_checker.sv
// port checker for station_switch_display
// assumes inputs change at the falling edge
`timescale 1ns/1ps
module station_checker (
   input wire        i_clk_sys,
   input wire        i_rst,
   input wire        i_display_select_switch,
   input wire        i_output_loss_jumper_present,
   input wire        i_output_loss_jumper_hold,
   input wire        i_comm_ok,
   input wire        i_wrong_slot,
   input wire [1:0]  i_diag_fail,
   input wire        i_lenient_mismatch_option,
   input wire [6:0]  o_station_addr,
   input wire        o_addr_valid,
   input wire        o_online_enable,
   input wire [4:0]  o_display_char,
   input wire        o_display_point,
   input wire [15:0] o_discrete_out
);
// ==========================================
// own copy of the start-up capture
reg [1:0] age_reg;
reg       sel_reg;
reg       hold_reg;
always @(posedge i_clk_sys or posedge i_rst) begin
   if (i_rst) begin
      age_reg <= 2'h0;
      sel_reg <= 1'b0;
      hold_reg <= 1'b0;
   end else begin
      if (age_reg == 2'h0) begin
         sel_reg <= i_display_select_switch;
         hold_reg <= i_output_loss_jumper_present & i_output_loss_jumper_hold;
      end
      if (age_reg != 2'h3) begin
         age_reg <= age_reg + 2'h1;
      end
   end
end
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (i_rst);
valid_range_a: assert property (age_reg != 2'h0 |->
   o_addr_valid == !(o_station_addr >= 7'h71 && o_station_addr <= 7'h7d)) else $error("bad valid");
addr_frozen_a: assert property (age_reg >= 2'h2 |-> $stable(o_station_addr))
   else $error("address moved");
online_gate_a: assert property (age_reg >= 2'h2 |-> o_online_enable ==
   (o_addr_valid && $past(i_diag_fail) == 2'h0 && !$past(i_wrong_slot))) else $error("online");
diag_code_a: assert property (age_reg >= 2'h2 && !sel_reg && $past(i_diag_fail) != 2'h0 |->
   o_display_char == ($past(i_diag_fail) == 2'h1 ? 5'h01 : $past(i_diag_fail) == 2'h2 ? 5'h0a
   : 5'h0e)) else $error("diag code");
slot_code_a: assert property (age_reg >= 2'h2 && !sel_reg && $past(i_diag_fail) == 2'h0
   && $past(i_wrong_slot) |-> o_display_char == 5'h11) else $error("slot code");
comm_code_a: assert property (age_reg >= 2'h2 && !sel_reg && $past(i_diag_fail) == 2'h0
   && !$past(i_wrong_slot) && !$past(i_comm_ok) |-> o_display_char == 5'h03) else $error("comm");
point_lit_a: assert property (age_reg >= 2'h2 |->
   o_display_point == (!sel_reg && $past(i_lenient_mismatch_option))) else $error("point");
addr_digits_a: assert property (age_reg >= 2'h2 && sel_reg |->
   o_display_char <= 5'h09 || o_display_char == 5'h1f) else $error("digit out of range");
loss_outputs_a: assert property (age_reg >= 2'h2 && !$past(i_comm_ok) |->
   o_discrete_out == (hold_reg ? $past(o_discrete_out) : 16'h0000)) else $error("loss outputs");
endmodule
bind station_switch_display station_checker u_station_checker (.*);

// File: tb/station_switch_display_test.sv
// self-checking bench for station_switch_display
// assumes short display counts of 4, 2 and 8 cycles
`timescale 1ns/1ps
module station_switch_display_test;
reg         clk = 1'b0;
reg         rst = 1'b1;
reg  [6:0]  sw = 7'h00;
reg         sel = 1'b0, spare = 1'b0, jp = 1'b0, jh = 1'b0, len = 1'b0;
reg         wmod = 1'b0, wslot = 1'b0, mism = 1'b0, link = 1'b0, cfg = 1'b0;
reg  [1:0]  diag = 2'h0;
reg  [15:0] img = 16'h0000;
reg  [6:0]  mst = 7'h00;
wire        comm, cfgr, valid, online, point;
wire [15:0] dimg, dout;
wire [6:0]  addr;
wire [4:0]  ch;
integer     n_fail = 0, n_tests = 0, i;
station_switch_display #(.DIGIT_ON_CYC(4), .SHORT_PAUSE_CYC(2), .LONG_PAUSE_CYC(8))
u_station_switch_display (.i_clk_sys(clk), .i_rst(rst), .i_address_switch(sw),
   .i_display_select_switch(sel), .i_spare_option_switch(spare),
   .i_output_loss_jumper_present(jp), .i_output_loss_jumper_hold(jh), .i_comm_ok(comm),
   .i_config_received(cfgr), .i_module_mismatch(mism), .i_wrong_module(wmod),
   .i_wrong_slot(wslot), .i_diag_fail(diag), .i_lenient_mismatch_option(len),
   .i_discrete_out(dimg), .o_station_addr(addr), .o_addr_valid(valid),
   .o_online_enable(online), .o_display_char(ch), .o_display_point(point),
   .o_discrete_out(dout));
fieldbus_master_model u_fieldbus_master_model (.i_clk_sys(clk), .i_link_up(link),
   .i_send_config(cfg), .i_image(img), .i_station_addr(mst), .o_comm_ok(comm),
   .o_config_received(cfgr), .o_discrete_out(dimg));
initial begin
   forever #5 clk = ~clk;
end
task check(input [15:0] seen, input [15:0] exp);
   begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   end
endtask
task end_of_test;
   begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   end
endtask
// ==========================================
// reset, then move every switch to prove it is ignored
task restart(input [6:0] a, input s, input p, input h);
   begin
      rst = 1'b1;
      sw = a;
      mst = a;
      sel = s;
      jp = p;
      jh = h;
      spare = ~spare;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      sw = ~a;
      sel = ~s;
      jh = ~h;
      spare = ~spare;
   end
endtask
task st(input [1:0] d, input s, l, c, w, m, n, input [4:0] e);
   begin
      diag = d;
      wslot = s;
      link = l;
      cfg = c;
      wmod = w;
      mism = m;
      len = n;
      repeat (3) @(negedge clk);
      check(ch, e);
      check(point, n);
      check(online, d == 2'h0 && !s);
   end
endtask
task t_loss(input p, input h, input [15:0] e);
   begin
      restart(7'h05, 1'b0, p, h);
      link = 1'b1;
      img = 16'h5a3c;
      repeat (3) @(negedge clk);
      check(dout, 16'h5a3c);
      link = 1'b0;
      repeat (4) @(negedge clk);
      check(dout, e);
   end
endtask
task t_address;
   reg [4:0] e;
   begin
      restart(7'h69, 1'b1, 1'b1, 1'b0);
      len = 1'b1;
      check(addr, 16'h0069);
      // skip the hundreds digit already on show, then catch the next at its start
      i = 0;
      while (ch === 5'h01 && i < 40) begin
         @(negedge clk);
         i = i + 1;
      end
      while (ch !== 5'h01 && i < 40) begin
         @(negedge clk);
         i = i + 1;
      end
      if (i == 40) begin
         n_fail = n_fail + 1;
         end_of_test;
      end
      for (i = 0; i < 28; i = i + 1) begin
         e = (i % 24 < 4) ? 5'h01 : (i % 24 < 6) ? 5'h1f : (i % 24 < 10) ? 5'h00 :
             (i % 24 < 12) ? 5'h1f : (i % 24 < 16) ? 5'h05 : 5'h1f;
         check(ch, e);
         @(negedge clk);
      end
      check(addr, 16'h0069);
   end
endtask
// edges of the invalid range, and one address either side
task t_range;
   begin
      for (i = 0; i < 4; i = i + 1) begin
         restart(i < 2 ? 7'h70 + i : 7'h7b + i, 1'b0, 1'b0, 1'b0);
         check(valid, i == 0 || i == 3);
         check(online, i == 0 || i == 3);
      end
   end
endtask
initial begin
   t_range;
   t_address;
   restart(7'h05, 1'b0, 1'b0, 1'b0);
   st(2'h1, 0, 1, 1, 0, 0, 0, 5'h01);
   st(2'h2, 1, 0, 1, 0, 0, 1, 5'h0a);
   st(2'h3, 0, 1, 1, 0, 0, 0, 5'h0e);
   st(2'h0, 1, 1, 1, 0, 0, 1, 5'h11);
   st(2'h0, 0, 0, 1, 1, 1, 0, 5'h03);
   st(2'h0, 0, 1, 0, 1, 1, 1, 5'h07);
   st(2'h0, 0, 1, 1, 1, 1, 0, 5'h10);
   st(2'h0, 0, 1, 1, 1, 1, 1, 5'h02);
   st(2'h0, 0, 1, 1, 0, 0, 1, 5'h00);
   t_loss(1'b1, 1'b0, 16'h0000);
   t_loss(1'b1, 1'b1, 16'h5a3c);
   t_loss(1'b0, 1'b1, 16'h0000);
   end_of_test;
end
endmodule
